/* logic/dmhbp_port.sv */
// Purpose: Host bus slave port, card mode or plug and play bus mode by strap.
// Assumes: Core side is on i_clock; all host pins are asynchronous to it.
// Notes: The core answers each o_acc_req pulse with one i_acc_done pulse.
// Operation
// R1: Bus mode follows the strap pin combinationally, regardless of reset or clock.
// R2: Strap high selects card mode; strap low selects plug and play bus mode.
// R3: Shared pins change meaning by mode following the fixed pin pairs.
// R4: Card mode decodes byte accesses only; lowest address bit picks the byte.
// R5: Card enable high floats data; read with enables low drives the byte.
// R6: Attribute writes need REG, card enable, write enable low, others high.
// R7: REG low routes to attribute or I/O space; high routes to common memory.
// R8: Memory read data is driven only while output enable is low.
// R9: Host keeps output enable high during memory writes.
// R10: Write data is taken on the write strobe; host keeps it high on reads.
// R11: Input acknowledge goes low only for answerable I/O reads once configured.
// R12: I/O strobes are ignored until the port is configured for I/O.
// R13: Pulse interrupts are low pulses of at least 0.5 us, high driven.
// R14: Level interrupts hold the line low while service is needed, high driven.
// R15: Reset clears the configuration option and returns to memory only state.
// R16: Status change only carries the wakeup indication.
// R17: Card mode asserts wait low until the access completes.
// R18: Bus mode decodes 24 address bits from latched and system lines.
// R19: Bus host marks I/O addresses with AEN low and valid addresses with BALE.
// R20: Bus mode drops channel ready at a memory access start, raises it when done.
// R21: Bus I/O read and write strobes become I/O register reads and writes.
// R22: Bit 7 is the most significant data bit in both modes.
// R23: Bus host uses memory read and memory write strobes for memory space.
// R24: Host strobes pass two flip-flops before any cycle decode.
// R25: Data bus floats whenever no read addressed to the port is in progress.
`timescale 1ns/1ns
`default_nettype none
`include "dmhbp_map.svh"

module dmhbp_port
	import dmhbp_pkg::*;
(
	input wire logic i_clock,
	input wire logic i_rst_b,
	input wire logic i_clk_en,
	input wire logic i_bus_select,
	input wire logic [14:0] i_addr,
	input wire logic [6:0] i_upper_pins,
	input wire logic i_ce1_b_la18,
	input wire logic i_oe_b_memr_b,
	input wire logic i_we_b_memw_b,
	input wire logic i_reg_b_aen,
	input wire logic i_iord_b,
	input wire logic i_iowr_b,
	input wire logic i_user0_rfrsh_b,
	input wire logic i_data,
	input wire logic [7:0] i_data_bus,
	output logic [7:0] o_data_bus,
	output logic o_data_oe,
	input wire logic i_inpack_la22,
	output logic o_inpack_b,
	output logic o_inpack_oe,
	output logic o_wait_rdy,
	output logic o_wait_rdy_oe,
	input wire logic i_stschg_bale,
	output logic o_stschg_b,
	output logic o_stschg_oe,
	output logic o_ireq_b,
	output logic o_ireq_oe,
	input wire logic i_cfg_wr,
	input wire logic [7:0] i_cfg_wdata,
	input wire logic i_irq_req,
	input wire logic i_wakeup,
	input wire logic i_acc_done,
	input wire logic [7:0] i_acc_rdata,
	output logic o_acc_req,
	output logic [1:0] o_acc_space,
	output logic o_acc_write,
	output logic [23:0] o_acc_addr,
	output logic [7:0] o_acc_wdata,
	output logic o_configured,
	output logic o_isa_mode
);

	// ----------------------------------------------------------------
	// Mode and pin synchronisers
	// ----------------------------------------------------------------
	logic isa_mode;
	logic [`DMHBP_SYNC_W-1:0] pin_raw;
	logic [`DMHBP_SYNC_W-1:0] sync1_reg;
	logic [`DMHBP_SYNC_W-1:0] sync2_reg;

	assign isa_mode = ~i_bus_select; // [R1] [R2]
	assign pin_raw = {i_data_bus, i_addr, i_upper_pins, i_inpack_la22, i_ce1_b_la18,
		i_oe_b_memr_b, i_we_b_memw_b, i_reg_b_aen, i_iord_b, i_iowr_b, i_user0_rfrsh_b,
		i_stschg_bale};

	// Each pin bit gets its own two stage chain; only stage two is read.
	genvar gi;
	generate
		for (gi = 0; gi < `DMHBP_SYNC_W; gi = gi + 1) begin : g_sync
			always_ff @(posedge i_clock or negedge i_rst_b) begin // [R24]
				if (!i_rst_b) begin
					sync1_reg[gi] <= 1'b1;
					sync2_reg[gi] <= 1'b1;
				end else if (i_clk_en) begin
					sync1_reg[gi] <= pin_raw[gi];
					sync2_reg[gi] <= sync1_reg[gi];
				end
			end
		end
	endgenerate

	logic [7:0] data_s;
	logic [14:0] addr_s;
	logic [6:0] upper_s;
	logic la22_s, ce1_b_s, oe_b_s, we_b_s, reg_b_s, iord_b_s, iowr_b_s, rfrsh_b_s, bale_s;

	assign {data_s, addr_s, upper_s, la22_s, ce1_b_s, oe_b_s, we_b_s, reg_b_s, iord_b_s,
		iowr_b_s, rfrsh_b_s, bale_s} = sync2_reg; // [R3] [R22]

	// ----------------------------------------------------------------
	// Configuration option
	// ----------------------------------------------------------------
	logic [7:0] cfg_reg;
	logic configured;
	logic level_mode;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			cfg_reg <= `DMHBP_CFG_RESET; // [R15]
		end else if (i_clk_en && i_cfg_wr) begin
			cfg_reg <= i_cfg_wdata;
		end
	end

	assign configured = (cfg_reg[`DMHBP_CFG_INDEX_W-1:0] != '0);
	assign level_mode = cfg_reg[`DMHBP_CFG_LEVEL_BIT];

	// ----------------------------------------------------------------
	// Cycle decode
	// ----------------------------------------------------------------
	logic [6:0] la_latch_reg;
	logic mem_rd, mem_wr, io_rd, io_wr, cyc_any;
	logic [23:0] cyc_addr;
	dmhbp_space_t cyc_space;

	// BALE marks the latched lines valid; they are held after it falls.
	always_ff @(posedge i_clock or negedge i_rst_b) begin // [R19]
		if (!i_rst_b) begin
			la_latch_reg <= 7'h00;
		end else if (i_clk_en && bale_s) begin
			la_latch_reg <= {upper_s[6], la22_s, upper_s[5], upper_s[4], upper_s[3],
				ce1_b_s, upper_s[2]};
		end
	end

	always_comb begin
		if (isa_mode) begin
			// Refresh cycles are not addressed to the port.
			mem_rd = ~oe_b_s & rfrsh_b_s; // [R23]
			mem_wr = ~we_b_s & rfrsh_b_s; // [R23]
			io_rd = ~iord_b_s & ~reg_b_s; // [R21] [R19]
			io_wr = ~iowr_b_s & ~reg_b_s; // [R21] [R19]
			cyc_addr = {la_latch_reg, upper_s[1], upper_s[0], addr_s}; // [R18]
			cyc_space = (io_rd | io_wr) ? SP_IO : SP_ISA_MEM;
		end else begin
			mem_rd = ~ce1_b_s & ~oe_b_s & we_b_s & iord_b_s & iowr_b_s; // [R5] [R10]
			mem_wr = ~ce1_b_s & oe_b_s & ~we_b_s & iord_b_s & iowr_b_s; // [R6] [R9]
			io_rd = ~ce1_b_s & ~reg_b_s & ~iord_b_s & iowr_b_s & oe_b_s & we_b_s;
			io_wr = ~ce1_b_s & ~reg_b_s & iord_b_s & ~iowr_b_s & oe_b_s & we_b_s;
			cyc_addr = {9'h000, addr_s}; // [R4]
			if (io_rd | io_wr) begin
				cyc_space = SP_IO;
			end else if (!reg_b_s) begin
				cyc_space = SP_ATTRIB; // [R7]
			end else begin
				cyc_space = SP_COMMON; // [R7]
			end
		end
		io_rd = io_rd & configured; // [R12]
		io_wr = io_wr & configured; // [R12]
		cyc_any = mem_rd | mem_wr | io_rd | io_wr;
	end

	// ----------------------------------------------------------------
	// Cycle sequencer
	// ----------------------------------------------------------------
	dmhbp_state_t state_reg;
	logic rd_reg;
	logic start;

	assign start = (state_reg == S_IDLE) & cyc_any;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state_reg <= S_IDLE;
			rd_reg <= 1'b0;
		end else if (i_clk_en) begin
			unique case (state_reg)
				S_IDLE: begin
					if (start) begin
						state_reg <= S_WAIT;
						rd_reg <= mem_rd | io_rd;
					end
				end
				S_WAIT: begin
					if (i_acc_done) begin
						state_reg <= S_HOLD;
					end
				end
				// Holding until the strobes drop stops one long strobe from
				// being taken as a second access.
				S_HOLD: begin
					if (!cyc_any) begin
						state_reg <= S_IDLE;
					end
				end
				default: begin
					state_reg <= S_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_acc_req <= 1'b0;
			o_acc_space <= SP_COMMON;
			o_acc_write <= 1'b0;
			o_acc_addr <= `DMHBP_ADDR_RESET;
			o_acc_wdata <= `DMHBP_DATA_RESET;
		end else if (i_clk_en) begin
			o_acc_req <= start;
			if (start) begin
				o_acc_space <= cyc_space;
				o_acc_write <= mem_wr | io_wr;
				o_acc_addr <= cyc_addr;
				o_acc_wdata <= data_s; // [R10]
			end
		end
	end

	// ----------------------------------------------------------------
	// Data bus
	// ----------------------------------------------------------------
	// The float follows the strobe release by the synchroniser delay, so the
	// host must allow about three clocks of read data hold time.
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_data_bus <= `DMHBP_DATA_RESET;
			o_data_oe <= 1'b0;
		end else if (i_clk_en) begin
			if (state_reg == S_WAIT && i_acc_done && rd_reg) begin
				o_data_bus <= i_acc_rdata; // [R22]
				o_data_oe <= 1'b1; // [R8]
			end else if (state_reg != S_HOLD || !cyc_any) begin
				o_data_oe <= 1'b0; // [R25] [R5]
			end
		end
	end

	// ----------------------------------------------------------------
	// Cycle extension and input acknowledge
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_wait_rdy <= 1'b1;
			o_wait_rdy_oe <= 1'b0;
		end else if (i_clk_en) begin
			if (start && (!isa_mode || cyc_space == SP_ISA_MEM)) begin
				o_wait_rdy <= 1'b0; // [R17] [R20]
				o_wait_rdy_oe <= 1'b1;
			end else if (state_reg != S_WAIT || i_acc_done) begin
				o_wait_rdy <= 1'b1; // [R17] [R20]
				o_wait_rdy_oe <= ~isa_mode;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_inpack_b <= 1'b1;
			o_inpack_oe <= 1'b0;
		end else if (i_clk_en) begin
			o_inpack_b <= ~(~isa_mode & io_rd); // [R11]
			o_inpack_oe <= ~isa_mode; // [R3]
		end
	end

	// ----------------------------------------------------------------
	// Interrupt request and status change
	// ----------------------------------------------------------------
	logic irq_prev_reg;
	logic [`DMHBP_PULSE_CNT_W-1:0] pulse_cnt_reg;
	logic irq_rise;

	assign irq_rise = i_irq_req & ~irq_prev_reg;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			irq_prev_reg <= 1'b0;
			pulse_cnt_reg <= '0;
		end else if (i_clk_en) begin
			irq_prev_reg <= i_irq_req;
			if (irq_rise && !level_mode && !isa_mode) begin
				pulse_cnt_reg <= `DMHBP_PULSE_CNT_W'(`DMHBP_IRQ_PULSE_CYC); // [R13]
			end else if (pulse_cnt_reg != '0) begin
				pulse_cnt_reg <= pulse_cnt_reg - 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_ireq_b <= 1'b1;
			o_ireq_oe <= 1'b0;
			o_stschg_b <= 1'b1;
			o_stschg_oe <= 1'b0;
		end else if (i_clk_en) begin
			if (level_mode) begin
				o_ireq_b <= ~i_irq_req; // [R14]
			end else begin
				o_ireq_b <= ~((irq_rise & ~isa_mode) | (pulse_cnt_reg > 6'h01)); // [R13]
			end
			o_ireq_oe <= ~isa_mode; // [R13] [R14]
			o_stschg_b <= ~i_wakeup; // [R16]
			o_stschg_oe <= ~isa_mode;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_configured <= 1'b0;
			o_isa_mode <= 1'b0;
		end else if (i_clk_en) begin
			o_configured <= configured; // [R15]
			o_isa_mode <= isa_mode;
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	logic [7:0] low_cnt_reg;

	always_ff @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			low_cnt_reg <= 8'h00;
		end else if (i_clk_en) begin
			low_cnt_reg <= o_ireq_b ? 8'h00 : ((low_cnt_reg == 8'hFF) ? 8'hFF : low_cnt_reg + 8'h01);
		end
	end

	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b || !i_clk_en);

	property p_data_float;
		(state_reg != S_HOLD) |-> !o_data_oe;
	endproperty
	a_data_float: assert property (p_data_float) else $error("data driven outside a read"); // [R25]

	property p_data_read_only;
		o_data_oe |-> (rd_reg && state_reg == S_HOLD);
	endproperty
	a_data_read_only: assert property (p_data_read_only) else $error("data driven on a write"); // [R8]

	property p_io_gated;
		(o_acc_req && o_acc_space == SP_IO) |-> $past(configured);
	endproperty
	a_io_gated: assert property (p_io_gated) else $error("I/O taken while unconfigured"); // [R12]

	property p_inpack;
		!o_inpack_b |-> ($past(configured) && !o_isa_mode);
	endproperty
	a_inpack: assert property (p_inpack) else $error("input acknowledge while unconfigured"); // [R11]

	property p_pulse_len;
		($rose(o_ireq_b) && !level_mode && !o_isa_mode) |-> (low_cnt_reg >= 8'(`DMHBP_IRQ_PULSE_CYC));
	endproperty
	a_pulse_len: assert property (p_pulse_len) else $error("interrupt pulse too short"); // [R13]

	property p_ireq_driven;
		(!isa_mode && !$past(isa_mode) && $past(i_rst_b)) |-> o_ireq_oe;
	endproperty
	a_ireq_driven: assert property (p_ireq_driven) else $error("interrupt line floated"); // [R14]

	property p_wait_start;
		(o_acc_req && !o_isa_mode) |-> (!o_wait_rdy && o_wait_rdy_oe);
	endproperty
	a_wait_start: assert property (p_wait_start) else $error("wait not asserted at start"); // [R17]

	property p_rdy_release;
		(state_reg == S_WAIT && i_acc_done) |=> o_wait_rdy;
	endproperty
	a_rdy_release: assert property (p_rdy_release) else $error("cycle not released when done"); // [R20]

	property p_mode_follow;
		i_bus_select |=> !o_isa_mode;
	endproperty
	a_mode_follow: assert property (p_mode_follow) else $error("strap high not card mode"); // [R2]

	c_card_read: cover property (o_acc_req && !o_acc_write ##[1:20] o_data_oe);
	c_io_write: cover property (o_acc_req && o_acc_write && o_acc_space == SP_IO);
	c_isa_mem: cover property (o_acc_req && o_acc_space == SP_ISA_MEM);
	c_irq_pulse: cover property ($fell(o_ireq_b) && !level_mode);

endmodule

`default_nettype wire

/* logic/dmhbp_map.svh */
// Purpose: Constants of the dual mode host bus port.
// Assumes: Included by its bare name from the port's package and module.
// Notes: Times are given in ns and turned into clock counts here.
`ifndef DMHBP_MAP_SVH
`define DMHBP_MAP_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DMHBP_CLK_PERIOD_NS 10
`define DMHBP_IRQ_PULSE_NS 500
`define DMHBP_IRQ_PULSE_CYC ((`DMHBP_IRQ_PULSE_NS + `DMHBP_CLK_PERIOD_NS - 1) / `DMHBP_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------
`define DMHBP_SYNC_W 39
`define DMHBP_CFG_INDEX_W 6
`define DMHBP_CFG_LEVEL_BIT 6
`define DMHBP_PULSE_CNT_W 6

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DMHBP_CFG_RESET 8'h00
`define DMHBP_DATA_RESET 8'h00
`define DMHBP_ADDR_RESET 24'h000000

`endif

/* logic/dmhbp_pkg.sv */
// Purpose: Types of the dual mode host bus port.
// Assumes: Constants live in dmhbp_map.svh.
// Notes: None.
`include "dmhbp_map.svh"

package dmhbp_pkg;

	// ----------------------------------------------------------------
	// Cycle sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_WAIT = 2'b01,
		S_HOLD = 2'b10
	} dmhbp_state_t;

	// ----------------------------------------------------------------
	// Target space of an access
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SP_COMMON = 2'b00,
		SP_ATTRIB = 2'b01,
		SP_IO = 2'b10,
		SP_ISA_MEM = 2'b11
	} dmhbp_space_t;

endpackage

/* test/dmhbp_host_model.sv */
// Purpose: Host side model that runs card and plug and play bus cycles.
// Assumes: Pins change just after a rising edge; released data shows its inverse.
// Notes: A strobe is held until ready is seen high, so stretched cycles are honoured.
`timescale 1ns/1ns
`default_nettype none

module dmhbp_host_model (
	input wire logic i_clock,
	input wire logic i_ready,
	output logic [14:0] o_addr,
	output logic [6:0] o_upper,
	output logic o_ce_b,
	output logic o_oe_b,
	output logic o_we_b,
	output logic o_reg_b,
	output logic o_iord_b,
	output logic o_iowr_b,
	output logic o_rfrsh_b,
	output logic o_la22,
	output logic o_bale,
	output logic [7:0] o_hd
);
	task automatic idle();
		{o_ce_b, o_oe_b, o_we_b, o_reg_b, o_iord_b, o_iowr_b, o_rfrsh_b} <= 7'h7F;
		o_bale <= 1'b0;
	endtask

	initial begin
		o_addr = 15'h0000;
		o_upper = 7'h00;
		o_la22 = 1'b0;
		o_hd = 8'h00;
		idle();
	end

	// A slow core may answer late; the host keeps a floor of ten edges.
	task automatic finish_cyc();
		int n;
		n = 0;
		repeat (10) @(posedge i_clock);
		while (i_ready !== 1'b1 && n < 200) begin
			@(posedge i_clock);
			n++;
		end
		idle();
		o_hd <= ~o_hd;
		repeat (5) @(posedge i_clock);
	endtask

	// Control order is card enable, output, write, attribute, I/O read, I/O write.
	task automatic card_cyc(input logic [5:0] ctl, input logic [14:0] a, input logic [7:0] d);
		@(posedge i_clock);
		o_addr <= a;
		{o_ce_b, o_oe_b, o_we_b, o_reg_b, o_iord_b, o_iowr_b} <= ctl;
		o_hd <= d;
		finish_cyc();
	endtask

	// Strobe order is refresh, memory read, memory write, I/O read, I/O write.
	task automatic isa_cyc(input logic [23:0] ad, input logic [4:0] st, input logic [7:0] d);
		@(posedge i_clock);
		o_addr <= ad[14:0];
		o_upper <= {ad[23], ad[21:19], ad[17:15]};
		o_ce_b <= ad[18];
		o_la22 <= ad[22];
		o_bale <= 1'b1;
		o_reg_b <= st[1] & st[0];
		repeat (2) @(posedge i_clock);
		o_bale <= 1'b0;
		o_upper[6:2] <= ~{ad[23], ad[21:19], ad[17]};
		o_ce_b <= ~ad[18];
		o_la22 <= ~ad[22];
		{o_rfrsh_b, o_oe_b, o_we_b, o_iord_b, o_iowr_b} <= st;
		o_hd <= d;
		finish_cyc();
	endtask
endmodule

`default_nettype wire

/* test/dmhbp_port_tb.sv */
// Purpose: Self-checking bench of the dual mode host bus port.
// Assumes: The core side is answered here with random latency and data.
// Notes: Requests are noted in a queue and checked when the port raises them.
`timescale 1ns/1ns
`default_nettype none

module dmhbp_port_tb;
	typedef struct packed {
		logic [1:0] sp;
		logic wr;
		logic wt;
		logic [23:0] ad;
		logic [23:0] m;
		logic [7:0] wd;
	} dmhbp_exp_t;

	logic i_clock, i_rst_b, i_bus_select, i_cfg_wr, i_irq_req, i_wakeup, i_acc_done;
	logic [7:0] i_cfg_wdata, i_acc_rdata, o_data_bus, o_acc_wdata, h_d, d, rd;
	logic o_data_oe, o_inpack_b, o_wait_rdy, o_wait_rdy_oe, o_stschg_b, o_ireq_b, o_ireq_oe;
	logic o_inpack_oe, o_stschg_oe;
	logic o_acc_req, o_acc_write, o_configured, o_isa_mode, oe_q, seen_ack;
	logic [1:0] o_acc_space, k;
	logic [23:0] o_acc_addr, ad;
	logic [14:0] h_addr, a;
	logic [6:0] h_up;
	logic h_ce_b, h_oe_b, h_we_b, h_reg_b, h_iord_b, h_iowr_b, h_rfrsh_b, h_la22, h_bale;
	logic [4:0] st;
	logic [5:0] mem_ctl [4] = '{6'h0F, 6'h17, 6'h0B, 6'h13};
	logic [4:0] isa_st [5] = '{5'h17, 5'h1B, 5'h07, 5'h1D, 5'h1E};
	int n_fail, compares, cyc, n, i, seed;
	dmhbp_exp_t eq [$];
	logic [7:0] rq [$];
	wire logic [7:0] d_bus = o_data_oe ? o_data_bus : h_d;
	wire logic rdy = o_wait_rdy_oe ? o_wait_rdy : 1'b1;

	dmhbp_port dmhbp_port_i (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_clk_en(1'b1),
		.i_bus_select(i_bus_select), .i_addr(h_addr), .i_upper_pins(h_up),
		.i_ce1_b_la18(h_ce_b), .i_oe_b_memr_b(h_oe_b), .i_we_b_memw_b(h_we_b),
		.i_reg_b_aen(h_reg_b), .i_iord_b(h_iord_b), .i_iowr_b(h_iowr_b),
		.i_user0_rfrsh_b(h_rfrsh_b), .i_data(1'b0), .i_data_bus(d_bus),
		.o_data_bus(o_data_bus), .o_data_oe(o_data_oe), .i_inpack_la22(h_la22),
		.o_inpack_b(o_inpack_b), .o_inpack_oe(o_inpack_oe), .o_wait_rdy(o_wait_rdy),
		.o_wait_rdy_oe(o_wait_rdy_oe), .i_stschg_bale(h_bale), .o_stschg_b(o_stschg_b),
		.o_stschg_oe(o_stschg_oe), .o_ireq_b(o_ireq_b), .o_ireq_oe(o_ireq_oe),
		.i_cfg_wr(i_cfg_wr),
		.i_cfg_wdata(i_cfg_wdata), .i_irq_req(i_irq_req), .i_wakeup(i_wakeup),
		.i_acc_done(i_acc_done), .i_acc_rdata(i_acc_rdata), .o_acc_req(o_acc_req),
		.o_acc_space(o_acc_space), .o_acc_write(o_acc_write), .o_acc_addr(o_acc_addr),
		.o_acc_wdata(o_acc_wdata), .o_configured(o_configured), .o_isa_mode(o_isa_mode));

	dmhbp_host_model dmhbp_host_model_i (.i_clock(i_clock), .i_ready(rdy), .o_addr(h_addr),
		.o_upper(h_up), .o_ce_b(h_ce_b), .o_oe_b(h_oe_b), .o_we_b(h_we_b), .o_reg_b(h_reg_b),
		.o_iord_b(h_iord_b), .o_iowr_b(h_iowr_b), .o_rfrsh_b(h_rfrsh_b), .o_la22(h_la22),
		.o_bale(h_bale), .o_hd(h_d));

	always #5 i_clock = ~i_clock;

	task automatic finish_test();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [31:0] ex, input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic chk_req(input dmhbp_exp_t e);
		dmhbp_exp_t g;
		g = e;
		g.sp = o_acc_space;
		g.wr = o_acc_write;
		g.wt = o_wait_rdy;
		g.ad = o_acc_addr & e.m;
		if (e.wr) g.wd = o_acc_wdata;
		e.ad = e.ad & e.m;
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch request expected %h seen %h", e, g);
		end
	endtask

	task automatic note(input logic [1:0] sp, input logic wr, input logic wt,
		input logic [23:0] adr, input logic [23:0] m, input logic [7:0] wd);
		eq.push_back({sp, wr, wt, adr, m, wd});
	endtask

	task automatic tick(input int c);
		repeat (c) @(posedge i_clock);
	endtask

	task automatic cfg(input logic [7:0] v);
		@(posedge i_clock);
		i_cfg_wr <= 1'b1;
		i_cfg_wdata <= v;
		@(posedge i_clock);
		i_cfg_wr <= 1'b0;
		tick(3);
	endtask

	// Watcher: a request or new read data with no note behind it is a mismatch.
	always @(posedge i_clock) begin
		cyc <= cyc + 1;
		oe_q <= o_data_oe;
		if (o_inpack_b === 1'b0) seen_ack <= 1'b1;
		if (o_data_oe === 1'b1 && oe_q === 1'b0) begin
			if (rq.size() == 0) rq.push_back(~o_data_bus);
			chk_val("read_data", rq.pop_front(), o_data_bus);
		end
		if (o_acc_req === 1'b1) begin
			if (eq.size() == 0) chk_val("request", 0, o_acc_req);
			else chk_req(eq.pop_front());
		end
		if (cyc > 20000) begin
			n_fail++;
			finish_test();
		end
	end

	initial begin
		forever begin
			@(posedge i_clock);
			if (o_acc_req === 1'b1) begin
				repeat ($urandom_range(1, 4)) @(posedge i_clock);
				rd = $urandom;
				i_acc_rdata <= rd;
				i_acc_done <= 1'b1;
				if (o_acc_write === 1'b0) rq.push_back(rd);
				@(posedge i_clock);
				i_acc_done <= 1'b0;
			end
		end
	end

	initial begin
		{i_clock, i_rst_b, i_cfg_wr, i_irq_req, i_acc_done, oe_q, seen_ack} = 7'h00;
		{i_bus_select, i_wakeup, i_cfg_wdata, i_acc_rdata} = 18'h30000;
		seed = $urandom(66);
		tick(4);
		i_rst_b <= 1'b1;
		tick(3);
		chk_val("configured", 0, o_configured);
		chk_val("isa_mode", 0, o_isa_mode);
		chk_val("pin_oe", 4'hF, {o_ireq_b, o_ireq_oe, o_inpack_oe, o_stschg_oe});
		chk_val("stschg", 0, o_stschg_b);
		for (i = 0; i < 8; i++) begin
			a = $urandom;
			a[0] = i[0];
			d = $urandom;
			k = i[2:1];
			note({1'b0, k[1]}, k[0], 1'b0, {9'h000, a}, 24'h007FFF, d);
			dmhbp_host_model_i.card_cyc(mem_ctl[k], a, d);
			chk_val("data_oe", 0, o_data_oe);
		end
		seen_ack = 1'b0;
		dmhbp_host_model_i.card_cyc(6'h19, a, d);
		dmhbp_host_model_i.card_cyc(6'h1A, a, d);
		chk_val("inpack_seen", 0, seen_ack);
		cfg(8'h01);
		chk_val("configured", 1, o_configured);
		note(2'h2, 1'b0, 1'b0, {9'h000, a}, 24'h007FFF, d);
		dmhbp_host_model_i.card_cyc(6'h19, a, d);
		chk_val("inpack_seen", 1, seen_ack);
		note(2'h2, 1'b1, 1'b0, {9'h000, a}, 24'h007FFF, d);
		dmhbp_host_model_i.card_cyc(6'h1A, a, d);
		i_irq_req <= 1'b1;
		n = 0;
		repeat (70) begin
			@(posedge i_clock);
			if (o_ireq_b === 1'b0) n++;
		end
		chk_val("pulse_len", 50, n);
		chk_val("ireq_idle", 2'b11, {o_ireq_b, o_ireq_oe});
		i_irq_req <= 1'b0;
		cfg(8'h41);
		i_irq_req <= 1'b1;
		tick(3);
		chk_val("ireq_level", 0, o_ireq_b);
		i_irq_req <= 1'b0;
		tick(3);
		chk_val("ireq_level", 2'b11, {o_ireq_b, o_ireq_oe});
		i_wakeup <= 1'b0;
		i_rst_b <= 1'b0;
		tick(2);
		i_rst_b <= 1'b1;
		tick(2);
		chk_val("configured", 0, o_configured);
		chk_val("stschg", 1, o_stschg_b);
		i_bus_select <= 1'b0;
		tick(3);
		chk_val("isa_mode", 4'h8, {o_isa_mode, o_ireq_oe, o_inpack_oe, o_stschg_oe});
		cfg(8'h01);
		// Refresh cycles carry no note, so any request they raise is flagged.
		for (i = 0; i < 5; i++) begin
			ad = $urandom;
			d = $urandom;
			st = isa_st[i];
			if (i < 2) note(2'h3, ~st[2], 1'b0, ad, 24'hFFFFFF, d);
			if (i > 2) note(2'h2, ~st[0], 1'b1, ad, 24'h007FFF, d);
			dmhbp_host_model_i.isa_cyc(ad, st, d);
			chk_val("data_oe", 0, o_data_oe);
		end
		chk_val("notes_left", 0, eq.size());
		chk_val("reads_left", 0, rq.size());
		finish_test();
	end
endmodule

`default_nettype wire
